/* File: include/asfic_regs.svh */
// register offsets, field positions, reset values and sizes of the sample queue block
// assumes inclusion by bare name from the design files and the bench
`ifndef ASFIC_REGS_SVH
`define ASFIC_REGS_SVH

// register offsets on the internal register port and the config reset value
`define ASFIC_ADDR_RANGE   8'h15
`define ASFIC_ADDR_QUEUE   8'h16
`define ASFIC_ADDR_IRQ     8'h17
`define ASFIC_RST_CFG      8'h00
// reserved bits 7 and 3 of the range register read as zero
`define ASFIC_RANGE_WMASK  8'h77

// range and resolution fields
`define ASFIC_WID_LSB      0
`define ASFIC_FS_LSB       4
// queue control fields
`define ASFIC_TH_LSB       0
`define ASFIC_QMODE_BIT    5
`define ASFIC_QEN_BIT      6
`define ASFIC_QRST_BIT     7
// interrupt control fields
`define ASFIC_IPP_BIT      0
`define ASFIC_IAH_BIT      1
`define ASFIC_IE_WAKE_BIT  2
`define ASFIC_IE_ACQ_BIT   3
`define ASFIC_IE_EMPTY_BIT 4
`define ASFIC_IE_FULL_BIT  5
`define ASFIC_IE_LEVEL_BIT 6
`define ASFIC_IE_COMB_BIT  7

// bit width codes and the result width each selects from the raw sample; the 14-bit code gives 12 with the queue on
`define ASFIC_WID_6        3'h0
`define ASFIC_WID_7        3'h1
`define ASFIC_WID_8        3'h2
`define ASFIC_WID_10       3'h3
`define ASFIC_WID_12       3'h4
`define ASFIC_WID_14       3'h5

// full-scale codes and their magnitude in g
`define ASFIC_FS_2G        3'h0
`define ASFIC_FS_4G        3'h1
`define ASFIC_FS_8G        3'h2
`define ASFIC_FS_16G       3'h3
`define ASFIC_FS_12G       3'h4

// sizes
`define ASFIC_RAW_WIDTH    14
`define ASFIC_Q_WIDTH      12
`define ASFIC_Q_DEPTH      32
`define ASFIC_Q_AW         5
`define ASFIC_CNT_W        6

`endif

/* File: include/asfic_pkg.sv */
// types shared by the sample queue block
// assumes nothing beyond a SystemVerilog compiler
package asfic_pkg;
	typedef logic signed [15:0] asfic_sample_type; // sign-extended result word
	typedef logic        [2:0]  asfic_code_type;   // three-bit select field
	typedef logic        [7:0]  asfic_byte_type;   // one register
endpackage : asfic_pkg

/* File: logic/asfic_queue_mem.sv */
// flop-based sample queue storage with registered read data and a whole-array clear
// assumes one clock; clear is synchronous and wins over a write in the same cycle
`timescale 1ns/1ps
`include "asfic_regs.svh"
module asfic_queue_mem #(
	parameter int W  = `ASFIC_Q_WIDTH,
	parameter int D  = `ASFIC_Q_DEPTH,
	parameter int AW = `ASFIC_Q_AW
) (
	input  wire logic          clk,
	input  wire logic          clr,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [W-1:0]  wdata,
	input  wire logic          re,
	input  wire logic [AW-1:0] raddr,
	output logic      [W-1:0]  rdata
);
	logic [W-1:0] mem_q [D]; // storage entries

	// one writer per entry; clear zeroes the contents
	for (genvar i = 0; i < D; i++)
	begin : g_ent
		always_ff @(posedge clk)
		begin
			if (clr)
				mem_q[i] <= '0;
			else if (we && waddr == AW'(i))
				mem_q[i] <= wdata;
		end
	end

	// read data held in a register until the next read or clear
	always_ff @(posedge clk)
	begin
		if (clr)
			rdata <= '0;
		else if (re)
			rdata <= mem_q[raddr];
	end
endmodule : asfic_queue_mem

/* File: logic/asfic_core.sv */
// sample formatting, 32-entry sample queue and interrupt pin control
// assumes samples and events arrive from logic on MCLK; registers come from the serial front end
`timescale 1ns/1ps
`include "asfic_regs.svh"

module asfic_core
	import asfic_pkg::*;
#(
	parameter int RAW_W = `ASFIC_RAW_WIDTH,
	parameter int Q_W   = `ASFIC_Q_WIDTH,
	parameter int Q_D   = `ASFIC_Q_DEPTH
) (
	input  wire logic             MCLK,
	input  wire logic             SRST,
	input  wire logic [7:0]       REG_ADDR,
	input  wire logic             REG_WR,
	input  wire logic [7:0]       REG_WDATA,
	output asfic_byte_type        REG_RDATA,
	input  wire logic             SMP_VALID,
	output logic                  SMP_READY,
	input  wire logic [RAW_W-1:0] SMP_DATA,
	input  wire logic             WAKE_EVENT,
	input  wire logic             COMBINED_WATCH_ACTIVE_MODE,
	input  wire logic             ACTIVITY_EVENT,
	input  wire logic             QUEUE_POP,
	output asfic_sample_type      QUEUE_DATA,
	output logic                  QUEUE_DATA_VALID,
	output asfic_sample_type      OUT_DATA,
	output logic                  NEW_DATA,
	output logic [5:0]            QUEUE_COUNT,
	output logic                  QUEUE_EMPTY,
	output logic                  QUEUE_FULL,
	output logic                  QUEUE_LEVEL,
	output logic [4:0]            FULL_SCALE_G,
	output logic                  IRQ_OUTPUT_PIN_O,
	output logic                  IRQ_OUTPUT_PIN_OE_N
);
	localparam int AW = $clog2(Q_D);          // queue pointer width
	localparam int CW = AW + 1;               // count reaches Q_D

	asfic_byte_type      range_q, queue_q, irq_q;  // three config registers
	asfic_code_type      wid_code;                 // bit_width_select
	logic [4:0]          queue_threshold;          // level for the level events
	logic                q_en, q_mode, q_rst;      // queue control bits
	logic                irq_pin_drive_select;     // 1 = push-pull
	logic                irq_polarity_select;      // 1 = active high
	logic [RAW_W-1:0]    buf0_q, buf1_q;           // two-entry input buffer
	logic [1:0]          buf_cnt_q, buf_cnt_d;     // entries held
	logic                buf_push, buf_pop;        // buffer handshakes
	logic [3:0]          shift;                    // right shift for the width
	asfic_sample_type    fmt;                      // formatted sample
	logic                stall, take, wr, rd;      // queue path decisions
	logic [AW-1:0]       wptr_q, rptr_q;           // queue pointers
	logic [CW-1:0]       cnt_q;                    // stored sample count
	logic [Q_W-1:0]      mem_rdata;                // queue read word
	logic                at_level;                 // count at or above threshold
	logic                act_d, act_q;             // any enabled source present

	assign wid_code             = range_q[`ASFIC_WID_LSB +: 3];
	assign queue_threshold      = queue_q[`ASFIC_TH_LSB +: 5];
	assign q_mode               = queue_q[`ASFIC_QMODE_BIT];
	assign q_en                 = queue_q[`ASFIC_QEN_BIT];
	assign q_rst                = queue_q[`ASFIC_QRST_BIT];
	assign irq_pin_drive_select = irq_q[`ASFIC_IPP_BIT];
	assign irq_polarity_select  = irq_q[`ASFIC_IAH_BIT];

	// config register writes
	// reset to zero
	always_ff @(posedge MCLK)
	begin
		if (SRST)
		begin
			range_q <= `ASFIC_RST_CFG;
			queue_q <= `ASFIC_RST_CFG;
			irq_q   <= `ASFIC_RST_CFG;
		end
		else if (REG_WR)
		begin
			if (REG_ADDR == `ASFIC_ADDR_RANGE)
				range_q <= REG_WDATA & `ASFIC_RANGE_WMASK;
			if (REG_ADDR == `ASFIC_ADDR_QUEUE)
				queue_q <= REG_WDATA;
			if (REG_ADDR == `ASFIC_ADDR_IRQ)
				irq_q <= REG_WDATA;
		end
	end

	// registered read-back; unmapped offsets answer zero
	always_ff @(posedge MCLK)
	begin
		if (SRST)
			REG_RDATA <= 8'h00;
		else
			unique case (REG_ADDR)
				`ASFIC_ADDR_RANGE: REG_RDATA <= range_q;
				`ASFIC_ADDR_QUEUE: REG_RDATA <= queue_q;
				`ASFIC_ADDR_IRQ:   REG_RDATA <= irq_q;
				default:           REG_RDATA <= 8'h00;
			endcase
	end

	// full-scale decode for the front end
	// code to g mapping
	always_ff @(posedge MCLK)
	begin
		if (SRST)
			FULL_SCALE_G <= 5'h02;
		else
			unique case (range_q[`ASFIC_FS_LSB +: 3])
				`ASFIC_FS_2G:  FULL_SCALE_G <= 5'h02;
				`ASFIC_FS_4G:  FULL_SCALE_G <= 5'h04;
				`ASFIC_FS_8G:  FULL_SCALE_G <= 5'h08;
				`ASFIC_FS_16G: FULL_SCALE_G <= 5'h10;
				`ASFIC_FS_12G: FULL_SCALE_G <= 5'h0C;
				default:       FULL_SCALE_G <= 5'h00; // reserved codes
			endcase
	end

	// two-entry buffer: a stall downstream holds words here, never drops them
	assign buf_push  = SMP_VALID & SMP_READY;
	assign buf_pop   = (buf_cnt_q != 2'h0) & take;
	assign buf_cnt_d = buf_cnt_q + 2'(buf_push) - 2'(buf_pop);

	always_ff @(posedge MCLK)
	begin
		if (SRST)
		begin
			buf_cnt_q <= 2'h0;
			SMP_READY <= 1'b1;
		end
		else
		begin
			buf_cnt_q <= buf_cnt_d;
			SMP_READY <= buf_cnt_d != 2'h2;
		end
	end

	// buffer data; head is always buf0
	always_ff @(posedge MCLK)
	begin
		if (buf_pop && (buf_cnt_q == 2'h2 || !buf_push))
			buf0_q <= buf1_q;
		if (buf_push && buf_cnt_q == (buf_pop ? 2'h1 : 2'h0))
			buf0_q <= SMP_DATA;
		else if (buf_push)
			buf1_q <= SMP_DATA;
	end

	// width select to shift amount
	// width codes
	always_comb
	begin
		unique case (wid_code)
			`ASFIC_WID_6:  shift = 4'h8;
			`ASFIC_WID_7:  shift = 4'h7;
			`ASFIC_WID_8:  shift = 4'h6;
			`ASFIC_WID_10: shift = 4'h4;
			`ASFIC_WID_12: shift = 4'h2;
			default:       shift = q_en ? 4'h2 : 4'h0; // 14 bits, 12 while the queue is on; reserved too
		endcase
	end

	assign fmt = asfic_sample_type'($signed({{(16 - RAW_W){buf0_q[RAW_W-1]}}, buf0_q})) >>> shift;

	// queue path decisions; normal mode stalls when full so no sample is lost
	// gated by enable
	assign at_level = q_en && queue_threshold != 5'h00 && cnt_q >= CW'(queue_threshold);
	assign stall    = q_en && (q_rst || (!q_mode && cnt_q == CW'(Q_D)));
	assign take     = !stall;
	assign wr       = q_en && buf_pop && !q_rst && cnt_q != CW'(Q_D) && !(q_mode && at_level);
	assign rd       = q_en && QUEUE_POP && !q_rst && cnt_q != '0;

	// pointers and count
	// reset bit clears
	always_ff @(posedge MCLK)
	begin
		if (SRST || q_rst)
		begin
			wptr_q <= '0;
			rptr_q <= '0;
			cnt_q  <= '0;
		end
		else
		begin
			wptr_q <= wptr_q + AW'(wr);
			rptr_q <= rptr_q + AW'(rd);
			cnt_q  <= cnt_q + CW'(wr) - CW'(rd);
		end
	end

	asfic_queue_mem #(
		.W  (Q_W),
		.D  (Q_D),
		.AW (AW)
	) u_mem (
		.clk   (MCLK),
		.clr   (SRST | q_rst),
		.we    (wr),
		.waddr (wptr_q),
		.wdata (fmt[Q_W-1:0]),
		.re    (rd),
		.raddr (rptr_q),
		.rdata (mem_rdata)
	);

	// read valid one cycle after an accepted pop
	always_ff @(posedge MCLK)
	begin
		if (SRST)
			QUEUE_DATA_VALID <= 1'b0;
		else
			QUEUE_DATA_VALID <= rd;
	end
	assign QUEUE_DATA = asfic_sample_type'($signed(mem_rdata));

	// bypass output register and new-data strobe
	// bypass when disabled
	always_ff @(posedge MCLK)
	begin
		if (SRST)
		begin
			OUT_DATA <= '0;
			NEW_DATA <= 1'b0;
		end
		else
		begin
			if (!q_en && buf_pop)
				OUT_DATA <= fmt;
			NEW_DATA <= !q_en ? buf_pop : wr;
		end
	end

	// status flags
	// defaults while disabled
	always_ff @(posedge MCLK)
	begin
		if (SRST)
		begin
			QUEUE_COUNT <= 6'h00;
			QUEUE_EMPTY <= 1'b1;
			QUEUE_FULL  <= 1'b0;
			QUEUE_LEVEL <= 1'b0;
		end
		else
		begin
			QUEUE_COUNT <= q_en ? 6'(cnt_q) : 6'h00;
			QUEUE_EMPTY <= !q_en || cnt_q == '0;
			QUEUE_FULL  <= q_en && cnt_q == CW'(Q_D);
			QUEUE_LEVEL <= at_level;
		end
	end

	// interrupt sources; event sources give one-cycle pin pulses
	// each source gated by its enable bit
	always_comb
	begin
		act_d = 1'b0;
		if (irq_q[`ASFIC_IE_WAKE_BIT] && WAKE_EVENT)
			act_d = 1'b1;
		if (irq_q[`ASFIC_IE_ACQ_BIT] && (q_en ? wr : buf_pop))
			act_d = 1'b1;
		if (q_en && irq_q[`ASFIC_IE_EMPTY_BIT] && cnt_q == '0)
			act_d = 1'b1;
		if (q_en && irq_q[`ASFIC_IE_FULL_BIT] && cnt_q == CW'(Q_D))
			act_d = 1'b1;
		if (irq_q[`ASFIC_IE_LEVEL_BIT] && at_level)
			act_d = 1'b1;
		if (irq_q[`ASFIC_IE_COMB_BIT] && COMBINED_WATCH_ACTIVE_MODE && ACTIVITY_EVENT)
			act_d = 1'b1;
	end

	// pin drive; open-drain only pulls toward zero
	// drive style
	always_ff @(posedge MCLK)
	begin
		if (SRST)
		begin
			act_q               <= 1'b0;
			IRQ_OUTPUT_PIN_O    <= 1'b0;
			IRQ_OUTPUT_PIN_OE_N <= 1'b1;
		end
		else
		begin
			act_q               <= act_d;
			IRQ_OUTPUT_PIN_O    <= irq_pin_drive_select ? (act_d == irq_polarity_select) : 1'b0;
			IRQ_OUTPUT_PIN_OE_N <= irq_pin_drive_select ? 1'b0 : (act_d == irq_polarity_select);
		end
	end

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (SRST);

	property p_qrst_clears;
		q_rst |=> cnt_q == '0 && QUEUE_DATA_VALID == 1'b0;
	endproperty
	a_qrst_clears: assert property (p_qrst_clears) else $error("queue reset left entries");

	property p_watermark_drop;
		q_en && q_mode && at_level && !rd && !q_rst |=> cnt_q == $past(cnt_q);
	endproperty
	a_watermark_drop: assert property (p_watermark_drop) else $error("watermark stored a sample");

	property p_bypass;
		!q_en && buf_pop |=> OUT_DATA == $past(fmt) && NEW_DATA;
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass sample not in output register");

	property p_no_store_off;
		!q_en && !q_rst |=> cnt_q == $past(cnt_q) && !QUEUE_DATA_VALID;
	endproperty
	a_no_store_off: assert property (p_no_store_off) else $error("queue moved while disabled");

	property p_normal_accept;
		q_en && !q_mode && !q_rst && buf_pop && cnt_q < CW'(Q_D) |-> wr;
	endproperty
	a_normal_accept: assert property (p_normal_accept) else $error("normal mode refused a sample");

	property p_defaults_off;
		!q_en ##1 !q_en |-> QUEUE_EMPTY && !QUEUE_FULL && QUEUE_COUNT == 6'h00;
	endproperty
	a_defaults_off: assert property (p_defaults_off) else $error("flags not at defaults");

	property p_empty_irq;
		q_en && irq_q[`ASFIC_IE_EMPTY_BIT] && cnt_q == '0 |=> act_q;
	endproperty
	a_empty_irq: assert property (p_empty_irq) else $error("empty source did not raise");

	property p_od_pin;
		!irq_pin_drive_select ##1 !irq_pin_drive_select |-> !IRQ_OUTPUT_PIN_O
			&& IRQ_OUTPUT_PIN_OE_N == (act_q == $past(irq_polarity_select));
	endproperty
	a_od_pin: assert property (p_od_pin) else $error("open-drain pin wrong");

	property p_pp_level;
		irq_pin_drive_select ##1 irq_pin_drive_select |-> !IRQ_OUTPUT_PIN_OE_N
			&& IRQ_OUTPUT_PIN_O == (act_q == $past(irq_polarity_select));
	endproperty
	a_pp_level: assert property (p_pp_level) else $error("push-pull level wrong");

	property p_cap12;
		q_en && wr |-> fmt[15:Q_W-1] == {(17 - Q_W){fmt[15]}};
	endproperty
	a_cap12: assert property (p_cap12) else $error("queue width above 12 bits");

	c_full: cover property (QUEUE_FULL);
	c_drop: cover property (q_en && q_mode && at_level && buf_pop);
	c_stall: cover property (!SMP_READY && SMP_VALID);
	c_irq: cover property (act_q && irq_pin_drive_select);
endmodule : asfic_core

/* File: dv/asfic_host_model.sv */
// host side model: pull-up on the interrupt line, queue reads
// assumes the core's pin split and queue read port, all on one clock
`timescale 1ns/1ps
module asfic_host_model
	import asfic_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             pin_o,
	input  wire logic             pin_oe_n,
	input  wire logic             data_valid,
	input  wire asfic_sample_type data,
	output logic                  pop,
	output logic                  line,
	output asfic_sample_type      last_word
);
	// released pin floats up to the pull-up level
	assign line = pin_oe_n ? 1'b1 : pin_o;

	// the valid strobe stands for one cycle only, so catch the word there
	always_ff @(posedge clk)
	begin
		if (data_valid)
			last_word <= data;
	end

	// one pop pulse, launched off the falling edge
	task automatic pop_word();
	begin
		@(negedge clk);
		pop = 1'b1;
		@(negedge clk);
		pop = 1'b0;
		repeat (2) @(negedge clk);
	end
	endtask : pop_word

	// idle until asked
	initial pop = 1'b0;
endmodule : asfic_host_model

/* File: dv/asfic_core_tb.sv */
// self-checking bench: registers, formatting, queue and interrupt pin
// assumes the core alone on one clock, host model on pin and read port
`timescale 1ns/1ps
`include "asfic_regs.svh"
module asfic_core_tb
	import asfic_pkg::*;
;
	logic             mclk = 1'b0;    // 100 MHz
	logic             srst = 1'b1;    // held 6 cycles
	logic             wr   = 1'b0;    // register strobe
	logic [7:0]       addr = 8'h00;   // register offset
	logic [7:0]       wdat = 8'h00;   // register data
	logic             sv   = 1'b0;    // sample offered
	logic [13:0]      sd   = 14'h0000; // raw sample
	logic             wake = 1'b0;    // wake pulse
	logic             comb = 1'b0;    // combined mode level
	logic             act  = 1'b0;    // activity pulse
	logic             pol  = 1'b0;    // polarity the bench set
	asfic_byte_type   rdat;
	asfic_sample_type qd, od, last_word;
	logic             rdy, pop, qv, nd, emp, ful, lvl, po, poe_n, line;
	logic [5:0]       cnt;
	logic [4:0]       fsg;
	asfic_byte_type   b;
	int               miscompares = 0;
	int               n_checks = 0;
	logic [4:0]       fs_tab [8] = '{5'h02, 5'h04, 5'h08, 5'h10, 5'h0C, 5'h00, 5'h00, 5'h00};
	int               sh_tab [7] = '{8, 7, 6, 4, 2, 0, 0};
	logic [13:0]      raw_tab [2] = '{14'h2ABC, 14'h1543};

	// free-running clock
	always #5 mclk = ~mclk;

	asfic_core u_asfic_core (
		.MCLK(mclk), .SRST(srst), .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdat),
		.REG_RDATA(rdat), .SMP_VALID(sv), .SMP_READY(rdy), .SMP_DATA(sd),
		.WAKE_EVENT(wake), .COMBINED_WATCH_ACTIVE_MODE(comb), .ACTIVITY_EVENT(act),
		.QUEUE_POP(pop), .QUEUE_DATA(qd), .QUEUE_DATA_VALID(qv), .OUT_DATA(od),
		.NEW_DATA(nd), .QUEUE_COUNT(cnt), .QUEUE_EMPTY(emp), .QUEUE_FULL(ful),
		.QUEUE_LEVEL(lvl), .FULL_SCALE_G(fsg), .IRQ_OUTPUT_PIN_O(po),
		.IRQ_OUTPUT_PIN_OE_N(poe_n)
	);
	asfic_host_model u_asfic_host_model (
		.clk(mclk), .pin_o(po), .pin_oe_n(poe_n), .data_valid(qv), .data(qd),
		.pop(pop), .line(line), .last_word(last_word)
	);

	// verdict and end of run, the single exit
	task automatic tally_and_finish();
	begin
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	end
	endtask : tally_and_finish

	// one comparison, four-state exact
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
	begin
		n_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	end
	endtask : chk

	// a bound ran out: count it and stop
	task automatic hang(input string nm);
	begin
		chk(nm, 16'h0001, 16'h0000);
		tally_and_finish();
	end
	endtask : hang

	// register write, one-cycle strobe
	task automatic wrr(input logic [7:0] a, input logic [7:0] d);
	begin
		@(negedge mclk);
		addr = a;
		wdat = d;
		wr = 1'b1;
		@(negedge mclk);
		wr = 1'b0;
	end
	endtask : wrr

	// register read, data registered behind the address
	task automatic rdr(input logic [7:0] a, output asfic_byte_type d);
	begin
		@(negedge mclk);
		addr = a;
		repeat (2) @(negedge mclk);
		d = rdat;
	end
	endtask : rdr

	// offer one sample, held until the ready edge
	task automatic send(input logic [13:0] raw);
		int n;
	begin
		@(negedge mclk);
		sv = 1'b1;
		sd = raw;
		n = 0;
		while (rdy !== 1'b1 && n < 40)
		begin
			@(negedge mclk);
			n++;
		end
		if (n == 40)
			hang("sample ready");
		@(negedge mclk);
		sv = 1'b0;
	end
	endtask : send

	// bounded wait for the new-sample pulse
	task automatic wait_new();
		int n;
	begin
		n = 0;
		while (nd !== 1'b1 && n < 20)
		begin
			@(negedge mclk);
			n++;
		end
		if (n == 20)
			hang("new sample");
	end
	endtask : wait_new

	// was the pin active at any point in the next four cycles
	task automatic irq_seen(input string nm, input logic exp);
		logic seen;
	begin
		seen = 1'b0;
		repeat (4)
		begin
			if ((line ^ ~pol) === 1'b1)
				seen = 1'b1;
			@(negedge mclk);
		end
		chk(nm, {15'h0, exp}, {15'h0, seen});
	end
	endtask : irq_seen

	// one-cycle event: 0 wake, 1 activity
	task automatic pulse(input int k);
	begin
		@(negedge mclk);
		if (k == 0)
			wake = 1'b1;
		else
			act = 1'b1;
		@(negedge mclk);
		wake = 1'b0;
		act = 1'b0;
	end
	endtask : pulse

	// expected formatting: sign-extend, then drop low bits
	function automatic asfic_sample_type fmt(input logic [13:0] raw, input int sh);
		asfic_sample_type x;
	begin
		x = {{2{raw[13]}}, raw};
		return x >>> sh;
	end
	endfunction : fmt

	// main sequence
	initial
	begin
		repeat (6) @(negedge mclk);
		srst = 1'b0;
		// three config registers plus one unmapped place
		for (int i = 0; i < 4; i++)
		begin
			rdr(8'h15 + 8'(i), b);
			chk("cfg reset", 16'h0000, {8'h00, b});
		end
		chk("pin released", 16'h0001, {15'h0, poe_n});
		wrr(`ASFIC_ADDR_RANGE, 8'hFF);
		rdr(`ASFIC_ADDR_RANGE, b);
		chk("range readback", 16'h0077, {8'h00, b});
		for (int i = 0; i < 8; i++)
		begin
			wrr(`ASFIC_ADDR_RANGE, {1'b0, 3'(i), 4'h0});
			repeat (3) @(negedge mclk);
			chk("full scale", {11'h0, fs_tab[i]}, {11'h0, fsg});
		end
		// bypass path, every width code, both signs
		wrr(`ASFIC_ADDR_IRQ, 8'h08);
		send(14'h0001);
		irq_seen("acq irq", 1'b1);
		for (int i = 0; i < 7; i++)
			for (int j = 0; j < 2; j++)
			begin
				wrr(`ASFIC_ADDR_RANGE, {5'h00, 3'(i)});
				send(raw_tab[j]);
				wait_new();
				chk("bypass word", fmt(raw_tab[j], sh_tab[i]), od);
			end
		// queue fill to refusal, 14-bit code narrowed
		wrr(`ASFIC_ADDR_IRQ, 8'h00);
		wrr(`ASFIC_ADDR_RANGE, 8'h05);
		wrr(`ASFIC_ADDR_QUEUE, 8'h5F);
		for (int i = 0; i < 34; i++)
			send(14'h2ABC ^ 14'(i));
		repeat (4) @(negedge mclk);
		chk("count full", 16'h0020, {10'h0, cnt});
		chk("full flag", 16'h0001, {15'h0, ful});
		chk("stall ready", 16'h0000, {15'h0, rdy});
		wrr(`ASFIC_ADDR_IRQ, 8'h20);
		irq_seen("full irq", 1'b1);
		chk("od drive", 16'h0000, {14'h0, poe_n, po});
		u_asfic_host_model.pop_word();
		chk("queue word", fmt(14'h2ABC, 2), last_word);
		repeat (4) @(negedge mclk);
		chk("no loss", 16'h0020, {10'h0, cnt});
		// reset bit clears while set
		wrr(`ASFIC_ADDR_QUEUE, 8'hDF);
		repeat (4) @(negedge mclk);
		chk("reset count", 16'h0000, {10'h0, cnt});
		chk("reset empty", 16'h0001, {15'h0, emp});
		wrr(`ASFIC_ADDR_QUEUE, 8'h9F);
		wrr(`ASFIC_ADDR_QUEUE, 8'h1F);
		repeat (6) @(negedge mclk);
		chk("off empty", 16'h0001, {15'h0, emp});
		wrr(`ASFIC_ADDR_IRQ, 8'h10);
		irq_seen("empty off", 1'b0);
		wrr(`ASFIC_ADDR_QUEUE, 8'h5F);
		irq_seen("empty irq", 1'b1);
		// push-pull, active high, then idle
		pol = 1'b1;
		wrr(`ASFIC_ADDR_IRQ, 8'h13);
		irq_seen("pp high", 1'b1);
		chk("pp drive", 16'h0001, {14'h0, poe_n, po});
		wrr(`ASFIC_ADDR_IRQ, 8'h03);
		repeat (4) @(negedge mclk);
		chk("pp idle", 16'h0000, {14'h0, poe_n, po});
		// watermark at threshold 4
		wrr(`ASFIC_ADDR_IRQ, 8'h43);
		wrr(`ASFIC_ADDR_QUEUE, 8'h64);
		for (int i = 0; i < 6; i++)
			send(14'h0100);
		repeat (4) @(negedge mclk);
		chk("mark count", 16'h0004, {10'h0, cnt});
		chk("level flag", 16'h0001, {15'h0, lvl});
		irq_seen("level irq", 1'b1);
		// event sources
		wrr(`ASFIC_ADDR_IRQ, 8'h07);
		pulse(0);
		irq_seen("wake irq", 1'b1);
		wrr(`ASFIC_ADDR_IRQ, 8'h83);
		pulse(1);
		irq_seen("comb off", 1'b0);
		comb = 1'b1;
		pulse(1);
		irq_seen("comb irq", 1'b1);
		tally_and_finish();
	end
endmodule : asfic_core_tb
